// [src/ofd_pkg.sv]
package ofd_pkg;
    // output function codes
    localparam logic [7:0] FUNC_NONE = 8'h00;
    localparam logic [7:0] FUNC_DETECT_ONE = 8'h01;
    localparam logic [7:0] FUNC_DETECT_TWO = 8'h02;
    localparam logic [7:0] FUNC_DETECT_THREE = 8'h03;
    localparam logic [7:0] FUNC_DETECT_FOUR = 8'h04;
    localparam logic [7:0] FUNC_RUN = 8'h0E;
    localparam logic [7:0] FUNC_TRIP = 8'h1D;
    // reset values of settings, frequency in 0.01 Hz units
    localparam logic [7:0] RELAY1_SEL_RST = FUNC_TRIP;
    localparam logic [7:0] RELAY2_SEL_RST = FUNC_RUN;
    localparam logic [7:0] OC_SEL_RST = FUNC_RUN;
    localparam logic [15:0] DETECT_FREQ_RST = 16'h0BB8;
    localparam logic [15:0] DETECT_BAND_RST = 16'h03E8;
    // AXI4-Lite register offsets
    localparam logic [7:0] ADDR_RELAY1_SEL = 8'h00;
    localparam logic [7:0] ADDR_RELAY2_SEL = 8'h04;
    localparam logic [7:0] ADDR_OC_SEL = 8'h08;
    localparam logic [7:0] ADDR_DETECT_FREQ = 8'h0C;
    localparam logic [7:0] ADDR_DETECT_BAND = 8'h10;
    localparam logic [7:0] ADDR_OUT_STATUS = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ofd_pkg

// [src/ofd_out_select.sv]
`timescale 1ns/100ps
// one output terminal: function select and registered level
module ofd_out_select
(
    // clock
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // setting and conditions
    input wire logic [7:0] funcSel,
    input wire logic freqDetectModeOne,
    input wire logic freqDetectModeTwo,
    input wire logic freqDetectModeThree,
    input wire logic freqDetectModeFour,
    input wire logic runActive,
    input wire logic tripActive,
    // terminal
    output logic outLevel
);
    logic sel;

    always_comb
    begin
        unique case (funcSel)
            ofd_pkg::FUNC_NONE: sel = 1'b0;
            ofd_pkg::FUNC_DETECT_ONE: sel = freqDetectModeOne;
            ofd_pkg::FUNC_DETECT_TWO: sel = freqDetectModeTwo;
            ofd_pkg::FUNC_DETECT_THREE: sel = freqDetectModeThree;
            ofd_pkg::FUNC_DETECT_FOUR: sel = freqDetectModeFour;
            ofd_pkg::FUNC_RUN: sel = runActive;
            ofd_pkg::FUNC_TRIP: sel = tripActive;
            // functions not built here stay inactive
            default: sel = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            outLevel <= 1'b0;
        else if (clkEn)
            outLevel <= sel;
    end

    a_none_inactive: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && funcSel == ofd_pkg::FUNC_NONE |=> !outLevel)
        else $error("output active with none selected");
endmodule : ofd_out_select

// [src/ofd_output_function.sv]
`timescale 1ns/100ps
module ofd_output_function
#(
    parameter int FREQ_W = 16,
    parameter bit HIGH_POWER = 1'b1
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // drive state, frequencies unsigned in 0.01 Hz
    input wire logic [FREQ_W-1:0] setFreq,
    input wire logic [FREQ_W-1:0] outputFreq,
    input wire logic [FREQ_W-1:0] operFreq,
    input wire logic accelerating,
    input wire logic decelerating,
    input wire logic runCmd,
    input wire logic outVoltageOn,
    input wire logic dcBraking,
    input wire logic tripActive,
    // terminals
    output logic relay1Out,
    output logic relay2Out,
    output logic openCollectorOut
);
    if (FREQ_W < 8 || FREQ_W > 32)
    begin : g_bad_width
        $error("FREQ_W out of range");
    end

    logic [7:0] relay1Sel_r;
    logic [7:0] relay2Sel_r;
    logic [7:0] ocSel_r;
    logic [FREQ_W-1:0] detectFreq_r;
    logic [FREQ_W-1:0] detectBand_r;
    logic [7:0] awAddr_r;
    logic awHeld_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic wHeld_r;
    logic [FREQ_W-1:0] halfBand;
    logic [FREQ_W-1:0] diffSetOut;
    logic [FREQ_W-1:0] diffOutOper;
    logic [FREQ_W-1:0] diffSetThr;
    logic freqDetectModeOne;
    logic freqDetectModeTwo;
    logic freqDetectModeThree;
    logic freqDetectModeFour;
    logic runActive;
    logic doWrite;

    assign halfBand = detectBand_r >> 1;
    assign diffSetOut = (setFreq >= outputFreq) ? setFreq - outputFreq
                                                : outputFreq - setFreq;
    assign diffOutOper = (outputFreq >= operFreq) ? outputFreq - operFreq
                                                  : operFreq - outputFreq;
    assign diffSetThr = (setFreq >= detectFreq_r) ? setFreq - detectFreq_r
                                                  : detectFreq_r - setFreq;
    assign freqDetectModeOne = diffSetOut < halfBand;
    assign freqDetectModeTwo = (diffSetThr < halfBand)
                               && freqDetectModeOne;
    assign freqDetectModeThree = diffOutOper < halfBand;

    // signed widening keeps both sides of the decel test exact
    always_comb
    begin
        logic signed [FREQ_W+1:0] lhs;
        logic signed [FREQ_W+1:0] rhs;
        lhs = $signed({2'b00, operFreq}) - $signed({2'b00, detectFreq_r});
        rhs = $signed({2'b00, detectFreq_r}) - $signed({2'b00, halfBand});
        if (accelerating)
            freqDetectModeFour = operFreq >= detectFreq_r;
        else if (decelerating)
            freqDetectModeFour = lhs > rhs;
        else
            freqDetectModeFour = 1'b0;
    end

    assign runActive = runCmd && outVoltageOn && !dcBraking;

    // write channel: address and data taken in either order
    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
        end
        else if (clkEn)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            else if (doWrite)
                awHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wHeld_r <= 1'b0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end
        else if (clkEn)
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            else if (doWrite)
                wHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (clkEn)
        begin
            s_axi_awready <= !awHeld_r && !(s_axi_awvalid && s_axi_awready)
                             && !s_axi_bvalid;
            s_axi_wready <= !wHeld_r && !(s_axi_wvalid && s_axi_wready)
                            && !s_axi_bvalid;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ofd_pkg::RESP_OKAY;
        end
        else if (clkEn)
        begin
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                unique case (awAddr_r)
                    ofd_pkg::ADDR_RELAY1_SEL, ofd_pkg::ADDR_OC_SEL,
                    ofd_pkg::ADDR_DETECT_FREQ, ofd_pkg::ADDR_DETECT_BAND:
                        s_axi_bresp <= ofd_pkg::RESP_OKAY;
                    ofd_pkg::ADDR_RELAY2_SEL:
                        s_axi_bresp <= HIGH_POWER ? ofd_pkg::RESP_OKAY
                                                  : ofd_pkg::RESP_SLVERR;
                    default: s_axi_bresp <= ofd_pkg::RESP_SLVERR;
                endcase
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // settings: byte lanes 0 and 1 carry data, and the upper lanes too when FREQ_W exceeds 16
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            relay1Sel_r <= ofd_pkg::RELAY1_SEL_RST;
            relay2Sel_r <= HIGH_POWER ? ofd_pkg::RELAY2_SEL_RST
                                      : ofd_pkg::FUNC_NONE;
            ocSel_r <= ofd_pkg::OC_SEL_RST;
            detectFreq_r <= FREQ_W'(ofd_pkg::DETECT_FREQ_RST);
            detectBand_r <= FREQ_W'(ofd_pkg::DETECT_BAND_RST);
        end
        else if (clkEn && doWrite)
        begin
            if (awAddr_r == ofd_pkg::ADDR_RELAY1_SEL && wStrb_r[0])
                relay1Sel_r <= wData_r[7:0];
            if (HIGH_POWER && awAddr_r == ofd_pkg::ADDR_RELAY2_SEL
                && wStrb_r[0])
                relay2Sel_r <= wData_r[7:0];
            if (awAddr_r == ofd_pkg::ADDR_OC_SEL && wStrb_r[0])
                ocSel_r <= wData_r[7:0];
            if (awAddr_r == ofd_pkg::ADDR_DETECT_FREQ && wStrb_r[0]
                && wStrb_r[1])
                detectFreq_r <= wData_r[FREQ_W-1:0];
            if (awAddr_r == ofd_pkg::ADDR_DETECT_BAND && wStrb_r[0]
                && wStrb_r[1])
                detectBand_r <= wData_r[FREQ_W-1:0];
        end
    end

    // read channel, one cycle latency
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ofd_pkg::RESP_OKAY;
        end
        else if (clkEn)
        begin
            s_axi_arready <= !s_axi_rvalid
                             && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= ofd_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    ofd_pkg::ADDR_RELAY1_SEL: s_axi_rdata <= 32'(relay1Sel_r);
                    ofd_pkg::ADDR_RELAY2_SEL:
                    begin
                        s_axi_rdata <= {24'h00_0000, relay2Sel_r};
                        if (!HIGH_POWER)
                            s_axi_rresp <= ofd_pkg::RESP_SLVERR;
                    end
                    ofd_pkg::ADDR_OC_SEL: s_axi_rdata <= 32'(ocSel_r);
                    ofd_pkg::ADDR_DETECT_FREQ:
                        s_axi_rdata <= 32'(detectFreq_r);
                    ofd_pkg::ADDR_DETECT_BAND:
                        s_axi_rdata <= 32'(detectBand_r);
                    ofd_pkg::ADDR_OUT_STATUS:
                        s_axi_rdata <= {29'h0000_0000, openCollectorOut,
                                        relay2Out, relay1Out};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= ofd_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    ofd_out_select u_relay1
    (
        .ref_clk, .rst, .clkEn, .funcSel(relay1Sel_r),
        .freqDetectModeOne, .freqDetectModeTwo,
        .freqDetectModeThree, .freqDetectModeFour,
        .runActive, .tripActive, .outLevel(relay1Out)
    );

    // low-power builds keep the second relay select at none
    ofd_out_select u_relay2
    (
        .ref_clk, .rst, .clkEn, .funcSel(relay2Sel_r),
        .freqDetectModeOne, .freqDetectModeTwo,
        .freqDetectModeThree, .freqDetectModeFour,
        .runActive, .tripActive, .outLevel(relay2Out)
    );

    ofd_out_select u_open_coll
    (
        .ref_clk, .rst, .clkEn, .funcSel(ocSel_r),
        .freqDetectModeOne, .freqDetectModeTwo,
        .freqDetectModeThree, .freqDetectModeFour,
        .runActive, .tripActive, .outLevel(openCollectorOut)
    );

    a_mode_one_out: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && relay1Sel_r == ofd_pkg::FUNC_DETECT_ONE
        |=> relay1Out == $past(diffSetOut < halfBand))
        else $error("mode one level wrong");
    a_mode_two_out: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && relay1Sel_r == ofd_pkg::FUNC_DETECT_TWO && !freqDetectModeOne
        |=> !relay1Out)
        else $error("mode two active without mode one");
    a_mode_three_out: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && ocSel_r == ofd_pkg::FUNC_DETECT_THREE
        |=> openCollectorOut == $past(diffOutOper < halfBand))
        else $error("mode three level wrong");
    a_accel_four: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && accelerating && operFreq >= detectFreq_r
        && relay1Sel_r == ofd_pkg::FUNC_DETECT_FOUR |=> relay1Out)
        else $error("mode four accel not asserted");
    a_decel_four: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !accelerating && decelerating && detectFreq_r >= halfBand
        && relay1Sel_r == ofd_pkg::FUNC_DETECT_FOUR
        && operFreq < detectFreq_r - halfBand |=> !relay1Out)
        else $error("mode four decel asserted early");
    a_low_power: assert property (@(posedge ref_clk) disable iff (rst)
        !HIGH_POWER |-> !relay2Out)
        else $error("second relay active in low power build");
    a_run_brake: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && ocSel_r == ofd_pkg::FUNC_RUN && dcBraking
        |=> !openCollectorOut)
        else $error("run output during braking");
    a_out_registered: assert property (@(posedge ref_clk) disable iff (rst)
        !clkEn |=> $stable(relay1Out) && $stable(openCollectorOut))
        else $error("output moved while frozen");
endmodule : ofd_output_function

// [dv/ofd_term_load.sv]
`timescale 1ns/100ps
// far-side equipment: relay coils and an opto input on the open collector
module ofd_term_load
(
    // terminals from the drive
    input wire logic relay1Out,
    input wire logic relay2Out,
    input wire logic openCollectorOut,
    // contact state seen by the equipment
    output logic [2:0] contactOn
);
    // no contact bounce modelled, so any glitch reaches the bench
    assign contactOn = {openCollectorOut, relay2Out, relay1Out};
endmodule : ofd_term_load

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
    logic ref_clk, rst, clkEn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [15:0] setFreq, outputFreq, operFreq, band;
    logic accelerating, decelerating, runCmd, outVoltageOn, dcBraking;
    logic tripActive, relay1Out, relay2Out, openCollectorOut, lowRelay2;
    logic [2:0] contactOn;
    int n_errors, checked;
    localparam logic [15:0] V_SET [6] = '{16'h0FA0, 16'h0FA0, 16'h112F,
        16'h1130, 16'h03E8, 16'h0000};
    localparam logic [15:0] V_OUT [6] = '{16'h0E74, 16'h0E10, 16'h0FA0,
        16'h0FA0, 16'h0514, 16'h0000};
    localparam logic [15:0] V_OPR [6] = '{16'h0E74, 16'h0FA0, 16'h0FA1,
        16'h1DB1, 16'h1DB0, 16'h0000};
    // {accel, decel, run, voltage, dc brake, trip}
    localparam logic [5:0] V_FLG [6] = '{6'h2D, 6'h2E, 6'h18, 6'h15,
        6'h1C, 6'h00};
    localparam logic [7:0] CODES [7] = '{ofd_pkg::FUNC_NONE,
        ofd_pkg::FUNC_DETECT_ONE, ofd_pkg::FUNC_DETECT_TWO,
        ofd_pkg::FUNC_DETECT_THREE, ofd_pkg::FUNC_DETECT_FOUR,
        ofd_pkg::FUNC_RUN, ofd_pkg::FUNC_TRIP};

    ofd_output_function DUT
    (
        .ref_clk, .rst, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .setFreq, .outputFreq, .operFreq, .accelerating,
        .decelerating, .runCmd, .outVoltageOn, .dcBraking, .tripActive,
        .relay1Out, .relay2Out, .openCollectorOut
    );
    // low-power build sees the same bus writes; only its relay2 is watched
    ofd_output_function #(.HIGH_POWER(1'b0)) DUT_LOW
    (
        .ref_clk, .rst, .clkEn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .setFreq, .outputFreq,
        .operFreq, .accelerating, .decelerating, .runCmd, .outVoltageOn,
        .dcBraking, .tripActive, .relay1Out(), .relay2Out(lowRelay2),
        .openCollectorOut()
    );
    ofd_term_load LOAD
    (
        .relay1Out, .relay2Out, .openCollectorOut, .contactOn
    );

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic int absd(input int a, input int b);
        return (a > b) ? a - b : b - a;
    endfunction : absd

    function automatic logic exp_fn(input logic [7:0] c);
        int h, sf, of, pf, th;
        logic m1;
        h = int'(band >> 1);
        sf = int'(setFreq);
        of = int'(outputFreq);
        pf = int'(operFreq);
        th = 4000;
        m1 = absd(sf, of) < h;
        case (c)
            ofd_pkg::FUNC_DETECT_ONE: return m1;
            ofd_pkg::FUNC_DETECT_TWO: return m1 && (absd(sf, th) < h);
            ofd_pkg::FUNC_DETECT_THREE: return absd(of, pf) < h;
            ofd_pkg::FUNC_DETECT_FOUR:
                return accelerating ? (pf >= th)
                    : (decelerating && ((pf - th) > (th - h)));
            ofd_pkg::FUNC_RUN: return runCmd && outVoltageOn && !dcBraking;
            ofd_pkg::FUNC_TRIP: return tripActive;
            default: return 1'b0;
        endcase
    endfunction : exp_fn

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(awDone && wDone));
        // only the watchdog ends a wait for the answer
        do
            @(posedge ref_clk);
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge ref_clk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge ref_clk);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        chk("rdata", ed, s_axi_rdata);
    endtask : axi_rd

    // apply vector i, then check each terminal one edge later
    task automatic drive(input int i, input logic [7:0] c1,
        input logic [7:0] c2, input logic [7:0] c3);
        @(posedge ref_clk);
        setFreq <= V_SET[i];
        outputFreq <= V_OUT[i];
        operFreq <= V_OPR[i];
        {accelerating, decelerating, runCmd, outVoltageOn, dcBraking,
            tripActive} <= V_FLG[i];
        @(posedge ref_clk);
        #1;
        chk("relay1", {31'h0, exp_fn(c1)}, {31'h0, contactOn[0]});
        chk("relay2", {31'h0, exp_fn(c2)}, {31'h0, contactOn[1]});
        chk("opencol", {31'h0, exp_fn(c3)}, {31'h0, contactOn[2]});
    endtask : drive

    task automatic test_reset_values;
        axi_rd(ofd_pkg::ADDR_RELAY1_SEL, 32'h0000_001D, ofd_pkg::RESP_OKAY);
        axi_rd(ofd_pkg::ADDR_RELAY2_SEL, 32'h0000_000E, ofd_pkg::RESP_OKAY);
        axi_rd(ofd_pkg::ADDR_OC_SEL, 32'h0000_000E, ofd_pkg::RESP_OKAY);
        axi_rd(ofd_pkg::ADDR_DETECT_FREQ, 32'h0000_0BB8, ofd_pkg::RESP_OKAY);
        axi_rd(ofd_pkg::ADDR_DETECT_BAND, 32'h0000_03E8, ofd_pkg::RESP_OKAY);
        axi_rd(8'h18, 32'h0000_0000, ofd_pkg::RESP_SLVERR);
        axi_wr(8'h18, 32'h0000_0001, ofd_pkg::RESP_SLVERR);
    endtask : test_reset_values

    // every code on every terminal, boundaries of half band and mode four
    task automatic test_mode_sweep;
        band = 16'h0321;
        axi_wr(ofd_pkg::ADDR_DETECT_FREQ, 32'h0000_0FA0, ofd_pkg::RESP_OKAY);
        axi_wr(ofd_pkg::ADDR_DETECT_BAND, {16'h0, band}, ofd_pkg::RESP_OKAY);
        axi_rd(ofd_pkg::ADDR_DETECT_BAND, {16'h0, band}, ofd_pkg::RESP_OKAY);
        for (int c = 0; c < 7; c++)
        begin
            axi_wr(ofd_pkg::ADDR_RELAY1_SEL, {24'h0, CODES[c]},
                ofd_pkg::RESP_OKAY);
            axi_wr(ofd_pkg::ADDR_RELAY2_SEL, {24'h0, CODES[c]},
                ofd_pkg::RESP_OKAY);
            axi_wr(ofd_pkg::ADDR_OC_SEL, {24'h0, CODES[c]},
                ofd_pkg::RESP_OKAY);
            for (int i = 0; i < 6; i++)
                drive(i, CODES[c], CODES[c], CODES[c]);
        end
    endtask : test_mode_sweep

    task automatic test_selects;
        axi_wr(ofd_pkg::ADDR_RELAY1_SEL, 32'h0000_0000, ofd_pkg::RESP_OKAY);
        axi_wr(ofd_pkg::ADDR_RELAY2_SEL, 32'h0000_000E, ofd_pkg::RESP_OKAY);
        axi_wr(ofd_pkg::ADDR_OC_SEL, 32'h0000_001D, ofd_pkg::RESP_OKAY);
        drive(0, 8'h00, 8'h0E, 8'h1D);
        chk("low_relay2", 32'h0, {31'h0, lowRelay2});
        axi_rd(ofd_pkg::ADDR_OUT_STATUS, 32'h0000_0006, ofd_pkg::RESP_OKAY);
        // a select write without lane 0 must leave the select alone
        s_axi_wstrb <= 4'hE;
        axi_wr(ofd_pkg::ADDR_RELAY1_SEL, 32'h0000_001D, ofd_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_rd(ofd_pkg::ADDR_RELAY1_SEL, 32'h0000_0000, ofd_pkg::RESP_OKAY);
    endtask : test_selects

    // outputs hold while enable is low and inputs move, then follow
    task automatic test_freeze;
        @(posedge ref_clk);
        clkEn <= 1'b0;
        {runCmd, tripActive} <= 2'b00;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("frozen", 32'h0000_0006, {29'h0, contactOn});
        @(posedge ref_clk);
        clkEn <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("thawed", 32'h0000_0000, {29'h0, contactOn});
    endtask : test_freeze

    task automatic test_done;
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        test_done();
    end

    initial
    begin
        n_errors = 0;
        checked = 0;
        band = 16'h03E8;
        {rst, clkEn} = 2'b11;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        {setFreq, outputFreq, operFreq} = '0;
        {accelerating, decelerating, runCmd, outVoltageOn} = 4'h0;
        {dcBraking, tripActive} = 2'b00;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset_values();
        test_mode_sweep();
        test_selects();
        test_freeze();
        test_done();
    end
endmodule : testbench
